//--- hw/mioap_pkg.sv
package mioap_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] MIOAP_OFF_CTRL      = 8'h00;
  localparam logic [7:0] MIOAP_OFF_FUNC      = 8'h04;
  localparam logic [7:0] MIOAP_OFF_INPUTS    = 8'h08;
  localparam logic [7:0] MIOAP_OFF_OUTPUTS   = 8'h0C;
  localparam logic [7:0] MIOAP_OFF_PRESET    = 8'h10;
  localparam logic [7:0] MIOAP_OFF_POSITION  = 8'h14;
  localparam logic [7:0] MIOAP_OFF_CAPTURE   = 8'h18;
  localparam logic [7:0] MIOAP_OFF_STATUS2   = 8'h1C;
  localparam logic [7:0] MIOAP_OFF_IRQ_STAT  = 8'h20;
  localparam logic [7:0] MIOAP_OFF_IRQ_EN    = 8'h24;
  localparam logic [7:0] MIOAP_OFF_IRQ_CLR   = 8'h28;
  localparam logic [7:0] MIOAP_OFF_OFFSET    = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // CTRL: write-one commands, then STATUS2 network error bit, line and IRQ counts
  localparam int MIOAP_CTRL_PRESET_BIT  = 0;
  localparam int MIOAP_CTRL_CLROFS_BIT  = 1;
  localparam int MIOAP_CTRL_REL2_BIT    = 2;
  localparam int MIOAP_CTRL_REL3_BIT    = 3;
  localparam int MIOAP_CTRL_RESTORE_BIT = 4;
  localparam int MIOAP_CTRL_NEGRST_BIT  = 5;
  localparam int MIOAP_STATUS2_NET_BIT  = 6;
  localparam int MIOAP_NUM_LINES        = 10;
  localparam int MIOAP_IRQ_BITS         = 4;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] MIOAP_FACTORY_OFFSET = 32'h0000_0000;
  localparam int          MIOAP_CLK_HZ         = 125_000_000;
  localparam int          MIOAP_SAMPLE_HZ      = 16_000;
  localparam int          MIOAP_SAMPLE_CYCLES  = MIOAP_CLK_HZ / MIOAP_SAMPLE_HZ;
  localparam int          MIOAP_BASE_CPR       = 4096;
  localparam logic [2:0]  MIOAP_SHIFT_MIN      = 3'h6;
  localparam logic [2:0]  MIOAP_SHIFT_MAX      = 3'h2;

  typedef enum logic [1:0] {
    MIOAP_IN6_GENERAL,
    MIOAP_IN6_GO,
    MIOAP_IN6_HOME
  } mioap_in6_mode_type;

  typedef struct packed {
    logic               pos_limit_en;
    logic               neg_limit_en;
    logic               capture_ext_en;
    logic               capture_int_en;
    mioap_in6_mode_type in6_mode;
    logic               brake_output_assign;
    logic               fault_output_assign;
    logic [2:0]         res_shift;
  } mioap_func_type;

  localparam mioap_func_type MIOAP_FUNC_RESET = '{
    pos_limit_en:        1'b1,
    neg_limit_en:        1'b1,
    capture_ext_en:      1'b0,
    capture_int_en:      1'b0,
    in6_mode:            MIOAP_IN6_GENERAL,
    brake_output_assign: 1'b0,
    fault_output_assign: 1'b0,
    res_shift:           3'h0
  };

endpackage

//--- hw/mioap_nv_store.sv
`timescale 1ns/1ps
// Nonvolatile offset word; survives aresetn, only written by preset or clear.
module mioap_nv_store (
  input  wire logic        aclk,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  output logic      [31:0] rd_data
);

  logic [31:0] mem_ff;

  // No reset on purpose: models retained storage across control resets
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem_ff <= wr_data;
    end
    rd_data <= mem_ff;
  end

endmodule

//--- hw/mioap_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Lines 0 and 1 are plain inputs, general purpose from reset.
// RULE2 - Line 2 defaults positive limit, line 3 negative; both releasable.
// RULE3 - Lines 4 and 5 select general purpose or index capture; default general.
// RULE4 - Line 6 selects general, go trigger or homing; general after reset.
// RULE5 - Motion is inhibited unless drive enable line 7 is high.
// RULE6 - Brake only on line 8; assign enables, deassign returns general purpose.
// RULE7 - Not-fault output only on line 9; deassign returns general purpose.
// RULE8 - Preset computes offset so position equals value; offset stored nonvolatile.
// RULE9 - Stored offset is applied to raw encoder position before any use.
// RULE10 - Offset clear restores factory offset and ignores the value.
// RULE11 - Resolution shift -2..2 relative to 4096 counts; left increases.
// RULE12 - Raw absolute position comes from an always-tracking encoder; no rehome.
// RULE13 - Status word 2 bit 6 sets on any network error.
// RULE14 - Control sample tick fixed at 16 kHz.
// RULE15 - Release makes a limit line general; restore returns line 2 to limit.
// RULE16 - Input word has logical input n in bit n.
// RULE17 - Software must not overwrite position directly; use preset.
// RULE18 - An active enabled limit blocks motion toward it only.
// RULE19 - Selected index capture latches position on line rising edge per sample.
module mioap_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [9:0]  line_in,
  output logic [9:0]       line_out,
  output logic [9:0]       line_oe_n,
  input  wire logic [31:0] raw_abs_position,
  input  wire logic [31:0] ext_enc_position,
  input  wire logic        motion_fwd_req,
  input  wire logic        motion_rev_req,
  input  wire logic        brake_release_req,
  input  wire logic        fault_active,
  input  wire logic        net_error_event,
  output logic             motion_fwd_allow,
  output logic             motion_rev_allow,
  output logic             go_trigger,
  output logic             home_event,
  output logic             sample_tick,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [9:0] in_meta_ff;
  logic [9:0] in_sync_ff;
  logic [9:0] in_prev_ff;
  always_ff @(posedge aclk) begin
    in_meta_ff <= line_in;
    in_sync_ff <= in_meta_ff;
  end
  // ----------------------------------------------------------------
  // Sample tick
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_ff;
  logic        tick_w;
  // RULE14 fixed sample rate
  assign tick_w = (tick_cnt_ff == 16'(mioap_pkg::MIOAP_SAMPLE_CYCLES - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_ff <= 16'h0000;
      sample_tick <= 1'b0;
    end else begin
      tick_cnt_ff <= tick_w ? 16'h0000 : tick_cnt_ff + 16'h0001;
      sample_tick <= tick_w;
    end
  end
  // ----------------------------------------------------------------
  // AXI write path
  // ----------------------------------------------------------------
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic        wr_go;
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_ff     <= 8'h00;
      s_axi_awready <= 1'b1;
      wdata_ff      <= 32'h0000_0000;
      s_axi_wready  <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff     <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        s_axi_wready <= 1'b1;
      end
    end
  end
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rresp   = 2'h0;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction
  logic wr_ctrl, wr_func, wr_out, wr_preset, wr_en, wr_clr;
  assign wr_ctrl   = wr_go && hit(awaddr_ff, mioap_pkg::MIOAP_OFF_CTRL);
  assign wr_func   = wr_go && hit(awaddr_ff, mioap_pkg::MIOAP_OFF_FUNC);
  assign wr_out    = wr_go && hit(awaddr_ff, mioap_pkg::MIOAP_OFF_OUTPUTS);
  assign wr_preset = wr_go && hit(awaddr_ff, mioap_pkg::MIOAP_OFF_PRESET);
  assign wr_en     = wr_go && hit(awaddr_ff, mioap_pkg::MIOAP_OFF_IRQ_EN);
  assign wr_clr    = wr_go && hit(awaddr_ff, mioap_pkg::MIOAP_OFF_IRQ_CLR);

  // ----------------------------------------------------------------
  // Function assignment
  // ----------------------------------------------------------------
  mioap_pkg::mioap_func_type func_ff;
  mioap_pkg::mioap_func_type nxt_func;
  mioap_pkg::mioap_func_type wr_func_val;
  logic                      shift_ok;
  assign wr_func_val = mioap_pkg::mioap_func_type'(wdata_ff[10:0]);
  // RULE11 shift range -2..2
  assign shift_ok = (wr_func_val.res_shift <= mioap_pkg::MIOAP_SHIFT_MAX) ||
                    (wr_func_val.res_shift >= mioap_pkg::MIOAP_SHIFT_MIN);
  always_comb begin
    nxt_func = func_ff;
    if (wr_func) begin
      nxt_func = wr_func_val;
      if (!shift_ok) begin
        nxt_func.res_shift = func_ff.res_shift;
      end
      if (wr_func_val.in6_mode == 2'h3) begin
        nxt_func.in6_mode = func_ff.in6_mode;
      end
    end
    // RULE15 release and restore
    if (wr_ctrl && wdata_ff[mioap_pkg::MIOAP_CTRL_REL2_BIT]) begin
      nxt_func.pos_limit_en = 1'b0;
    end
    if (wr_ctrl && wdata_ff[mioap_pkg::MIOAP_CTRL_REL3_BIT]) begin
      nxt_func.neg_limit_en = 1'b0;
    end
    if (wr_ctrl && wdata_ff[mioap_pkg::MIOAP_CTRL_RESTORE_BIT]) begin
      nxt_func.pos_limit_en = 1'b1;
    end
    if (wr_ctrl && wdata_ff[mioap_pkg::MIOAP_CTRL_NEGRST_BIT]) begin
      nxt_func.neg_limit_en = 1'b1;
    end
  end
  // RULE1 RULE2 RULE3 RULE4 reset defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_ff <= mioap_pkg::MIOAP_FUNC_RESET;
    end else begin
      func_ff <= nxt_func;
    end
  end

  // ----------------------------------------------------------------
  // Position offset
  // ----------------------------------------------------------------
  logic [31:0] nv_rd;
  logic        nv_wr;
  logic [31:0] nv_wdata;
  logic [31:0] pos_word_ff;
  logic        clr_req;
  logic [31:0] abs_pos;
  logic [31:0] scaled_pos;
  assign clr_req = wr_ctrl && wdata_ff[mioap_pkg::MIOAP_CTRL_CLROFS_BIT];
  // RULE8 preset offset; RULE10 clear ignores value
  assign nv_wr    = clr_req || (wr_ctrl && wdata_ff[mioap_pkg::MIOAP_CTRL_PRESET_BIT]);
  assign nv_wdata = clr_req ? mioap_pkg::MIOAP_FACTORY_OFFSET
                            : pos_word_ff - raw_abs_position;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_word_ff <= 32'h0000_0000;
    end else if (wr_preset) begin
      pos_word_ff <= wdata_ff;
    end
  end
  mioap_nv_store u_nv (
    .aclk    (aclk),
    .wr_en   (nv_wr),
    .wr_data (nv_wdata),
    .rd_data (nv_rd)
  );
  // RULE9 RULE12 offset on tracked raw position
  assign abs_pos = raw_abs_position + nv_rd;
  // RULE11 resolution shift
  always_comb begin
    case (func_ff.res_shift)
      3'h1:    scaled_pos = {abs_pos[30:0], 1'b0};
      3'h2:    scaled_pos = {abs_pos[29:0], 2'b00};
      3'h7:    scaled_pos = {abs_pos[31], abs_pos[31:1]};
      3'h6:    scaled_pos = {{2{abs_pos[31]}}, abs_pos[31:2]};
      default: scaled_pos = abs_pos;
    endcase
  end

  // ----------------------------------------------------------------
  // Line functions
  // ----------------------------------------------------------------
  logic [31:0] cap_pos_ff;
  logic [31:0] gp_out_ff;
  logic        rise4, rise5, rise6;
  logic        pos_hit, neg_hit;
  logic [9:0]  nxt_oe_n;
  logic [9:0]  nxt_out;
  assign rise4 = in_sync_ff[4] && !in_prev_ff[4];
  assign rise5 = in_sync_ff[5] && !in_prev_ff[5];
  assign rise6 = in_sync_ff[6] && !in_prev_ff[6];
  assign pos_hit = func_ff.pos_limit_en && in_sync_ff[2];
  assign neg_hit = func_ff.neg_limit_en && in_sync_ff[3];
  always_comb begin
    nxt_out  = {gp_out_ff[9:8], 2'b00, gp_out_ff[5:4], 4'h0};
    nxt_oe_n = {~gp_out_ff[25:24], 2'b11, ~gp_out_ff[21:20], 4'hF};
    // RULE3 capture lines are inputs
    if (func_ff.capture_ext_en) nxt_oe_n[4] = 1'b1;
    if (func_ff.capture_int_en) nxt_oe_n[5] = 1'b1;
    // RULE6 brake engaged unless released and enabled
    if (func_ff.brake_output_assign) begin
      nxt_out[8]  = brake_release_req && in_sync_ff[7];
      nxt_oe_n[8] = 1'b0;
    end
    // RULE7 not-fault output
    if (func_ff.fault_output_assign) begin
      nxt_out[9]  = !fault_active;
      nxt_oe_n[9] = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_prev_ff       <= 10'h000;
      cap_pos_ff       <= 32'h0000_0000;
      gp_out_ff        <= 32'h0000_0000;
      line_out         <= 10'h000;
      line_oe_n        <= 10'h3FF;
      motion_fwd_allow <= 1'b0;
      motion_rev_allow <= 1'b0;
      go_trigger       <= 1'b0;
      home_event       <= 1'b0;
    end else begin
      if (wr_out) gp_out_ff <= wdata_ff;
      line_out  <= nxt_out;
      line_oe_n <= nxt_oe_n;
      go_trigger <= 1'b0;
      home_event <= 1'b0;
      if (tick_w) begin
        in_prev_ff <= in_sync_ff;
        // RULE19 index capture per sample
        if (func_ff.capture_ext_en && rise4) cap_pos_ff <= ext_enc_position;
        else if (func_ff.capture_int_en && rise5) cap_pos_ff <= scaled_pos;
        // RULE4 go or home on line 6
        go_trigger <= rise6 && (func_ff.in6_mode == mioap_pkg::MIOAP_IN6_GO);
        home_event <= rise6 && (func_ff.in6_mode == mioap_pkg::MIOAP_IN6_HOME);
      end
      // RULE5 drive enable; RULE18 directional limit
      motion_fwd_allow <= in_sync_ff[7] && motion_fwd_req && !pos_hit;
      motion_rev_allow <= in_sync_ff[7] && motion_rev_req && !neg_hit;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupts
  // ----------------------------------------------------------------
  logic        net_err_ff;
  logic [3:0]  irq_stat_ff;
  logic [3:0]  irq_en_ff;
  logic [3:0]  irq_ev;
  assign irq_ev = {net_error_event, pos_hit, neg_hit, tick_w &&
                   ((func_ff.capture_ext_en && rise4) || (func_ff.capture_int_en && rise5))};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      net_err_ff  <= 1'b0;
      irq_stat_ff <= 4'h0;
      irq_en_ff   <= 4'h0;
      irq         <= 1'b0;
    end else begin
      // RULE13 sticky network error, set wins
      net_err_ff  <= net_error_event || (net_err_ff && !(wr_clr && wdata_ff[3]));
      irq_stat_ff <= irq_ev | (irq_stat_ff & ~(wr_clr ? wdata_ff[3:0] : 4'h0));
      if (wr_en) irq_en_ff <= wdata_ff[3:0];
      irq <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // ----------------------------------------------------------------
  // AXI response and read path
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [7:0]  ra;
  assign ra = s_axi_araddr;
  // RULE16 input n in bit n
  assign rd_mux =
    hit(ra, mioap_pkg::MIOAP_OFF_FUNC)     ? {21'h0, func_ff} :
    hit(ra, mioap_pkg::MIOAP_OFF_INPUTS)   ? {22'h0, in_sync_ff} :
    hit(ra, mioap_pkg::MIOAP_OFF_OUTPUTS)  ? gp_out_ff :
    hit(ra, mioap_pkg::MIOAP_OFF_PRESET)   ? pos_word_ff :
    hit(ra, mioap_pkg::MIOAP_OFF_POSITION) ? scaled_pos :
    hit(ra, mioap_pkg::MIOAP_OFF_CAPTURE)  ? cap_pos_ff :
    hit(ra, mioap_pkg::MIOAP_OFF_STATUS2)  ? {25'h0, net_err_ff, 6'h00} :
    hit(ra, mioap_pkg::MIOAP_OFF_IRQ_STAT) ? {28'h0, irq_stat_ff} :
    hit(ra, mioap_pkg::MIOAP_OFF_IRQ_EN)   ? {28'h0, irq_en_ff} :
    hit(ra, mioap_pkg::MIOAP_OFF_OFFSET)   ? nv_rd : 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid  <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      if (wr_go) s_axi_bvalid <= 1'b1;
      else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid  <= 1'b1;
        s_axi_arready <= 1'b0;
        s_axi_rdata   <= rd_mux;
      end else if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

//--- tb/mioap_sva.sv
`timescale 1ns/1ps
module mioap_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [9:0]  line_in,
  input wire logic [9:0]  line_oe_n,
  input wire logic        motion_fwd_req,
  input wire logic        motion_rev_req,
  input wire logic        motion_fwd_allow,
  input wire logic        motion_rev_allow,
  input wire logic        go_trigger,
  input wire logic        home_event,
  input wire logic        sample_tick
);
  // ----------------------------------------------------------------
  // Tick spacing counter
  // ----------------------------------------------------------------
  logic [12:0] gap_ff;
  logic        seen_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || sample_tick) begin
      gap_ff <= 13'h0000;
    end else begin
      gap_ff <= gap_ff + 13'h0001;
    end
    seen_ff <= aresetn && (seen_ff || sample_tick);
  end
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  input_pins_a: assert property (line_oe_n[3:0] == 4'hF && line_oe_n[7:6] == 2'h3)
    else $error("input only line driven");
  drive_inhibit_a: assert property ((!line_in[7]) [*4] |-> !motion_fwd_allow && !motion_rev_allow)
    else $error("motion allowed without drive enable");
  fwd_cause_a: assert property (motion_fwd_allow |-> $past(motion_fwd_req))
    else $error("forward allowed without request");
  rev_cause_a: assert property (motion_rev_allow |-> $past(motion_rev_req))
    else $error("reverse allowed without request");
  tick_period_a: assert property (sample_tick && seen_ff |-> gap_ff == 13'h1E83)
    else $error("sample tick period wrong");
  tick_gap_a: assert property (seen_ff |-> gap_ff <= 13'h1E83)
    else $error("sample tick missing");
  line6_pulse_a: assert property (go_trigger || home_event |=> !go_trigger && !home_event)
    else $error("line six event longer than one cycle");
  line6_excl_a: assert property (!(go_trigger && home_event))
    else $error("go and home together");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule

//--- tb/mioap_field.sv
`timescale 1ns/1ps
module mioap_field (
  input  wire logic        aclk,
  input  wire logic [9:0]  sw_level,
  input  wire logic        enc_run,
  input  wire logic [9:0]  line_out,
  input  wire logic [9:0]  line_oe_n,
  output logic      [9:0]  line_in,
  output logic      [31:0] raw_abs_position,
  output logic      [31:0] ext_enc_position
);
  initial raw_abs_position = 32'h0001_2340;
  initial ext_enc_position = 32'h00AB_0000;
  // Tracks without reset
  // No reset input: the count runs on while the block is held in reset
  always @(posedge aclk) begin
    if (enc_run) begin
      raw_abs_position <= raw_abs_position + 32'h0000_0001;
      ext_enc_position <= ext_enc_position + 32'h0000_0003;
    end
  end
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      line_in[i] = line_oe_n[i] ? sw_level[i] : line_out[i];
    end
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, enc_run = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0, net_error_event = 1'b0;
  logic        motion_fwd_req = 1'b0, motion_rev_req = 1'b0;
  logic        brake_release_req = 1'b0, fault_active = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [9:0]  sw_level = 10'h080;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, raw_abs_position, ext_enc_position;
  logic [9:0]  line_in, line_out, line_oe_n;
  logic        motion_fwd_allow, motion_rev_allow, go_trigger, home_event, sample_tick, irq;
  int          failures = 0, total_checks = 0, cycles = 0;
  mioap_top u_mioap_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_in, .line_out, .line_oe_n,
    .raw_abs_position, .ext_enc_position, .motion_fwd_req, .motion_rev_req,
    .brake_release_req, .fault_active, .net_error_event, .motion_fwd_allow,
    .motion_rev_allow, .go_trigger, .home_event, .sample_tick, .irq);
  mioap_field u_mioap_field (.aclk, .sw_level, .enc_run, .line_out, .line_oe_n, .line_in,
    .raw_abs_position, .ext_enc_position);
  always #4 aclk = ~aclk;
  // Ceiling covers three tick watches plus register traffic
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // Ready is sampled at the falling edge; it cannot move before the next rise
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = ta | (s_axi_awvalid & s_axi_awready);
      tw = tw | (s_axi_wvalid & s_axi_wready);
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    logic t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      t = s_axi_rvalid;
      @(posedge aclk);
    end while (!t);
    s_axi_rready <= 1'b1;
    @(negedge aclk);
    d = s_axi_rdata;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic watch(output logic [1:0] s);
    s = 2'b00;
    repeat (9000) begin
      @(negedge aclk);
      s = s | {home_event, go_trigger};
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    logic [31:0] d;
    axi_rd(mioap_pkg::MIOAP_OFF_FUNC, d);
    chk(d, 32'h0000_0600);
    chk({22'h0, line_oe_n}, 32'h0000_03FF);
    axi_rd(8'h30, d);
    chk(d, 32'h0);
    axi_wr(mioap_pkg::MIOAP_OFF_PRESET, 32'h1234_5678);
    axi_wr(mioap_pkg::MIOAP_OFF_CTRL, 32'h2);
    axi_rd(mioap_pkg::MIOAP_OFF_OFFSET, d);
    chk(d, 32'h0);
  endtask
  task automatic t_inputs;
    logic [31:0] d;
    @(posedge aclk);
    sw_level <= 10'h2A5;
    cyc(4);
    axi_rd(mioap_pkg::MIOAP_OFF_INPUTS, d);
    chk(d, 32'h0000_02A5);
    chk(d & 32'hF, 32'h5);
  endtask
  task automatic t_limits;
    logic [31:0] d;
    @(posedge aclk);
    motion_fwd_req <= 1'b1;
    motion_rev_req <= 1'b1;
    cyc(6);
    chk(motion_fwd_allow, 1'b0);
    chk(motion_rev_allow, 1'b1);
    axi_wr(mioap_pkg::MIOAP_OFF_CTRL, 32'h4);
    cyc(4);
    chk(motion_fwd_allow, 1'b1);
    axi_wr(mioap_pkg::MIOAP_OFF_CTRL, 32'h10);
    cyc(4);
    chk(motion_fwd_allow, 1'b0);
    axi_rd(mioap_pkg::MIOAP_OFF_IRQ_STAT, d);
    chk(d[2], 1'b1);
    axi_wr(mioap_pkg::MIOAP_OFF_IRQ_EN, 32'h4);
    cyc(3);
    chk(irq, 1'b1);
    axi_wr(mioap_pkg::MIOAP_OFF_IRQ_EN, 32'h0);
    cyc(3);
    chk(irq, 1'b0);
    @(posedge aclk);
    sw_level <= 10'h001;
    cyc(6);
    axi_wr(mioap_pkg::MIOAP_OFF_IRQ_CLR, 32'h4);
    axi_rd(mioap_pkg::MIOAP_OFF_IRQ_STAT, d);
    chk(d[2], 1'b0);
    chk(motion_fwd_allow | motion_rev_allow, 1'b0);
    @(posedge aclk);
    sw_level <= 10'h088;
    net_error_event <= 1'b1;
    @(posedge aclk);
    net_error_event <= 1'b0;
    axi_rd(mioap_pkg::MIOAP_OFF_STATUS2, d);
    chk(d, 32'h40);
    axi_wr(mioap_pkg::MIOAP_OFF_IRQ_CLR, 32'h8);
    axi_rd(mioap_pkg::MIOAP_OFF_STATUS2, d);
    chk(d, 32'h0);
    chk(motion_rev_allow, 1'b0);
  endtask
  // Position is set only through preset, never overwritten
  task automatic t_position;
    logic [31:0] d, r0, p;
    @(posedge aclk);
    enc_run <= 1'b0;
    axi_wr(mioap_pkg::MIOAP_OFF_PRESET, 32'h0000_5000);
    axi_wr(mioap_pkg::MIOAP_OFF_CTRL, 32'h1);
    r0 = raw_abs_position;
    axi_rd(mioap_pkg::MIOAP_OFF_POSITION, d);
    chk(d, 32'h0000_5000);
    axi_rd(mioap_pkg::MIOAP_OFF_OFFSET, d);
    chk(d, 32'h0000_5000 - r0);
    @(posedge aclk);
    aresetn <= 1'b0;
    enc_run <= 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    enc_run <= 1'b0;
    axi_rd(mioap_pkg::MIOAP_OFF_POSITION, d);
    p = 32'h0000_5000 + raw_abs_position - r0;
    chk(d, p);
    axi_wr(mioap_pkg::MIOAP_OFF_FUNC, 32'h601);
    axi_rd(mioap_pkg::MIOAP_OFF_POSITION, d);
    chk(d, p << 1);
    axi_wr(mioap_pkg::MIOAP_OFF_FUNC, 32'h606);
    axi_rd(mioap_pkg::MIOAP_OFF_POSITION, d);
    chk(d, p >> 2);
    axi_wr(mioap_pkg::MIOAP_OFF_FUNC, 32'h603);
    axi_rd(mioap_pkg::MIOAP_OFF_POSITION, d);
    chk(d, p >> 2);
    axi_wr(mioap_pkg::MIOAP_OFF_FUNC, 32'h600);
    axi_wr(mioap_pkg::MIOAP_OFF_CTRL, 32'h2);
    axi_rd(mioap_pkg::MIOAP_OFF_POSITION, d);
    chk(d, raw_abs_position);
  endtask
  task automatic t_capture;
    logic [31:0] d;
    logic [1:0]  s;
    axi_wr(mioap_pkg::MIOAP_OFF_FUNC, 32'h720);
    @(posedge aclk);
    sw_level <= 10'h0D0;
    watch(s);
    chk(s, 2'b01);
    axi_rd(mioap_pkg::MIOAP_OFF_CAPTURE, d);
    chk(d, ext_enc_position);
    axi_rd(mioap_pkg::MIOAP_OFF_IRQ_STAT, d);
    chk(d[0], 1'b1);
    axi_wr(mioap_pkg::MIOAP_OFF_FUNC, 32'h740);
    @(posedge aclk);
    sw_level <= 10'h090;
    watch(s);
    chk(s, 2'b00);
    @(posedge aclk);
    sw_level <= 10'h0D0;
    watch(s);
    chk(s, 2'b10);
  endtask
  task automatic t_outputs;
    @(posedge aclk);
    brake_release_req <= 1'b1;
    axi_wr(mioap_pkg::MIOAP_OFF_FUNC, 32'h618);
    cyc(4);
    chk(line_oe_n[9:8], 2'b00);
    chk(line_out[9:8], 2'b11);
    @(posedge aclk);
    fault_active <= 1'b1;
    cyc(4);
    chk(line_out[9], 1'b0);
    axi_wr(mioap_pkg::MIOAP_OFF_FUNC, 32'h600);
    cyc(4);
    chk(line_oe_n[9:8], 2'b11);
    axi_wr(mioap_pkg::MIOAP_OFF_OUTPUTS, 32'h0010_0010);
    cyc(4);
    chk({line_oe_n[5:4], line_out[4]}, 3'b101);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_inputs();
    t_limits();
    t_position();
    t_capture();
    t_outputs();
    final_report();
  end
endmodule
bind mioap_top mioap_sva u_mioap_sva (.aclk, .aresetn, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .line_in, .line_oe_n, .motion_fwd_req, .motion_rev_req, .motion_fwd_allow,
  .motion_rev_allow, .go_trigger, .home_event, .sample_tick);
